//--- logic/qrs_pkg.sv
// Purpose: Shared constants and types for the quad read, program and erase sequencer
// Assumes: Link side runs on the serial clock, core side on clk_sys
// Notes:   Cycle times are in microseconds, the clock period in nanoseconds; cycle counts derive from them
package qrs_pkg;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] QRS_OPC_QREAD = 8'hEB;
   localparam logic [7:0] QRS_OPC_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] QRS_OPC_PROG = 8'h02;
   localparam logic [7:0] QRS_OPC_QPROG = 8'h33;
   localparam logic [7:0] QRS_OPC_ERASE_SMALL = 8'h20;
   localparam logic [7:0] QRS_OPC_ERASE_MID = 8'h52;
   localparam logic [3:0] QRS_CONT_NIBBLE = 4'hA;
   // ------------------------------------------------------------
   // Geometry and timing
   // ------------------------------------------------------------
   localparam int QRS_PAGE_BYTES = 256;
   localparam logic [23:0] QRS_SMALL_BLK_MASK = 24'h00_0FFF;
   localparam logic [23:0] QRS_MID_BLK_MASK = 24'h00_7FFF;
   localparam logic [23:0] QRS_WRAP_BASE = 24'h00_0008;
   localparam int QRS_SPI_DUMMY_CLKS = 6;
   localparam int QRS_MODE_CLKS = 2;
   localparam int QRS_CLK_NS = 40;
   localparam int QRS_PROG_TIME_US = 800;
   localparam int QRS_SMALL_ERASE_TIME_US = 50000;
   localparam int QRS_MID_ERASE_TIME_US = 150000;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      QRS_LK_CMD = 3'b000, QRS_LK_ADDR = 3'b001, QRS_LK_MODE = 3'b010,
      QRS_LK_DUMMY = 3'b011, QRS_LK_RDATA = 3'b100, QRS_LK_WDATA = 3'b101,
      QRS_LK_EDONE = 3'b110, QRS_LK_IGNORE = 3'b111
   } qrs_lk_st_e;
   typedef enum logic [1:0] {
      QRS_OP_NONE = 2'b00, QRS_OP_READ = 2'b01, QRS_OP_PROG = 2'b10, QRS_OP_ERASE = 2'b11
   } qrs_op_e;
   typedef enum logic [1:0] {
      QRS_SY_IDLE = 2'b00, QRS_SY_COPY = 2'b01, QRS_SY_WAIT = 2'b10
   } qrs_sy_st_e;
   typedef struct packed {
      logic qe;
      logic fwm;
      logic wrap_en;
      logic [1:0] wrap_len;
      logic [1:0] dsel;
      logic wl;
      logic busy;
   } qrs_cfg_s;
   typedef struct packed {
      qrs_lk_st_e st;
      qrs_op_e op;
      logic qd;
      logic big;
      logic [4:0] cnt;
      logic [7:0] sh;
      logic [23:0] addr;
      logic nib;
      logic cont;
      logic write_enable_cmd;
      logic done;
   } qrs_lk_s;
   typedef struct packed {
      logic wr_en;
      logic erase;
      logic big;
      logic [23:0] addr;
      logic [7:0] data;
   } qrs_arr_s;
   typedef struct packed {
      qrs_sy_st_e st;
      logic csd;
      logic busy;
      logic wl;
      logic [7:0] idx;
      logic [15:0] page;
      logic [31:0] tmr;
      qrs_arr_s arr;
   } qrs_sy_s;
endpackage : qrs_pkg

//--- logic/qrs_sync2.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain
// Assumes: Each bit is an independent or quasi-static level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module qrs_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : qrs_sync2

//--- logic/qrs_pagebuf.sv
// Purpose: Page load buffer with per-byte loaded marks
// Assumes: Written on the link clock, read by the core once the frame is over
// Notes:   Read port is combinational
`timescale 1ns/1ps
module qrs_pagebuf #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 8
) (
   input wire logic wclk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata,
   output logic rmark
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [DEPTH-1:0] mark_q;

   always_ff @(posedge wclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge wclk or negedge rst_n) begin
      if (!rst_n) begin
         mark_q <= '0;
      end else if (clr) begin
         mark_q <= '0;
      end else if (we) begin
         mark_q[waddr] <= 1'b1;
      end
   end

   assign rdata = mem[raddr];
   assign rmark = mark_q[raddr];
endmodule : qrs_pagebuf

//--- logic/qrs_seq.sv
// Purpose: Quad read, page program and block erase command sequencer
// Assumes: sck is the host serial clock, stopped while cs_n is high
// Notes:   Frame results are read by the core side after cs_n is seen high
`timescale 1ns/1ps
module qrs_seq
   import qrs_pkg::*;
#(
   parameter int SPI_DUMMY_CLKS = QRS_SPI_DUMMY_CLKS,
   parameter int PROG_TIME_US = QRS_PROG_TIME_US,
   parameter int SMALL_ERASE_TIME_US = QRS_SMALL_ERASE_TIME_US,
   parameter int MID_ERASE_TIME_US = QRS_MID_ERASE_TIME_US
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out_q,
   output logic [3:0] io_oe_q,
   output logic [23:0] rd_addr_q,
   input wire logic [7:0] rd_data,
   input wire logic quad_enable_bit,
   input wire logic four_wire_command_mode,
   input wire logic wrap_en,
   input wire logic [1:0] wrap_len,
   input wire logic [1:0] dummy_sel,
   output logic busy_q,
   output logic write_latch_flag_q,
   output qrs_pkg::qrs_arr_s arr_q
);
   import qrs_pkg::*;

   // ------------------------------------------------------------
   // Derived counts
   // ------------------------------------------------------------
   localparam int PROG_CYC_I = PROG_TIME_US * 1000 / QRS_CLK_NS;
   localparam int SMALL_CYC_I = SMALL_ERASE_TIME_US * 1000 / QRS_CLK_NS;
   localparam int MID_CYC_I = MID_ERASE_TIME_US * 1000 / QRS_CLK_NS;
   localparam logic [31:0] PROG_CYC = 32'(PROG_CYC_I < 1 ? 1 : PROG_CYC_I);
   localparam logic [31:0] SMALL_CYC = 32'(SMALL_CYC_I < 1 ? 1 : SMALL_CYC_I);
   localparam logic [31:0] MID_CYC = 32'(MID_CYC_I < 1 ? 1 : MID_CYC_I);
   localparam logic [4:0] SPI_REM = 5'(SPI_DUMMY_CLKS - QRS_MODE_CLKS);

   if (SPI_DUMMY_CLKS < 3 || SPI_DUMMY_CLKS > 16 || PROG_TIME_US < 1 ||
       SMALL_ERASE_TIME_US < 1 || MID_ERASE_TIME_US < 1) begin : g_bad_param
      $error("qrs_seq: parameter out of range");
   end

   // ------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------
   qrs_cfg_s cfg;
   qrs_cfg_s cfg_raw;
   logic cs_s;
   qrs_sy_s y_q;
   qrs_sy_s y_d;
   qrs_lk_s s_q;
   qrs_lk_s s_d;

   assign cfg_raw = '{qe: quad_enable_bit, fwm: four_wire_command_mode, wrap_en: wrap_en,
                      wrap_len: wrap_len, dsel: dummy_sel, wl: y_q.wl, busy: y_q.busy};

   qrs_sync2 #(.W($bits(qrs_cfg_s))) u_cfg_sync (
      .clk(sck),
      .rst_n(rst_n),
      .d(cfg_raw),
      .q(cfg)
   );

   qrs_sync2 #(.W(1)) u_cs_sync (
      .clk(clk_sys),
      .rst_n(rst_n),
      .d(!cs_n),
      .q(cs_s)
   );

   // ------------------------------------------------------------
   // Link side: frame start marker
   // ------------------------------------------------------------
   logic fl_q;

   always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         fl_q <= 1'b0;
      end else if (cs_n) begin
         fl_q <= 1'b0;
      end else begin
         fl_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Link side: command sequencer
   // ------------------------------------------------------------
   qrs_lk_s c;
   logic q4;
   logic [7:0] sh;
   logic [4:0] cnt;
   logic [4:0] rem;
   logic [23:0] wmask;
   logic pb_clr;
   logic pb_we;
   logic [7:0] pb_rdata;
   logic pb_rmark;

   always_comb begin
      c = s_q;
      if (!fl_q) begin
         c.st = s_q.cont ? QRS_LK_ADDR : QRS_LK_CMD;
         c.op = s_q.cont ? QRS_OP_READ : QRS_OP_NONE;
         c.cnt = '0;
         c.qd = 1'b0;
         c.big = 1'b0;
         c.write_enable_cmd = 1'b0;
         c.done = 1'b0;
         c.nib = 1'b0;
      end
      s_d = c;
      pb_clr = 1'b0;
      pb_we = 1'b0;
      case (c.st)
         QRS_LK_CMD: q4 = cfg.fwm;
         QRS_LK_ADDR: q4 = (c.op == QRS_OP_READ) || cfg.fwm || c.qd;
         QRS_LK_WDATA: q4 = cfg.fwm || c.qd;
         default: q4 = 1'b1;
      endcase
      sh = q4 ? {c.sh[3:0], io_in} : {c.sh[6:0], io_in[0]};
      cnt = c.cnt + (q4 ? 5'd4 : 5'd1);
      if (!cfg.fwm) begin
         rem = SPI_REM;
      end else if (cfg.dsel == 2'b11) begin
         rem = 5'd6;
      end else if (cfg.dsel == 2'b10) begin
         rem = 5'd4;
      end else begin
         rem = 5'd2;
      end
      wmask = (QRS_WRAP_BASE << cfg.wrap_len) - 24'h00_0001;
      case (c.st)
         QRS_LK_CMD: begin
            s_d.sh = sh;
            s_d.cnt = cnt;
            if (cnt == 5'd8) begin
               s_d.cnt = '0;
               s_d.st = QRS_LK_IGNORE;
               if (sh == QRS_OPC_QREAD && cfg.qe && !cfg.busy) begin
                  s_d.st = QRS_LK_ADDR;
                  s_d.op = QRS_OP_READ;
               end else if (sh == QRS_OPC_WRITE_ENABLE_CMD) begin
                  s_d.write_enable_cmd = 1'b1;
               end else if (!cfg.busy && cfg.wl && (sh == QRS_OPC_PROG ||
                            (sh == QRS_OPC_QPROG && cfg.qe))) begin
                  s_d.st = QRS_LK_ADDR;
                  s_d.op = QRS_OP_PROG;
                  s_d.qd = (sh == QRS_OPC_QPROG);
                  pb_clr = 1'b1;
               end else if (!cfg.busy && cfg.wl && (sh == QRS_OPC_ERASE_SMALL ||
                            sh == QRS_OPC_ERASE_MID)) begin
                  s_d.st = QRS_LK_ADDR;
                  s_d.op = QRS_OP_ERASE;
                  s_d.big = (sh == QRS_OPC_ERASE_MID);
               end
            end
         end
         QRS_LK_ADDR: begin
            s_d.addr = q4 ? {c.addr[19:0], io_in} : {c.addr[22:0], io_in[0]};
            s_d.cnt = cnt;
            if (cnt == 5'd24) begin
               s_d.cnt = '0;
               if (c.op == QRS_OP_READ) begin
                  s_d.st = QRS_LK_MODE;
               end else if (c.op == QRS_OP_PROG) begin
                  s_d.st = QRS_LK_WDATA;
               end else begin
                  s_d.st = QRS_LK_EDONE;
                  s_d.done = 1'b1;
               end
            end
         end
         QRS_LK_MODE: begin
            s_d.sh = sh;
            s_d.cnt = cnt;
            if (cnt == 5'd8) begin
               s_d.cnt = '0;
               s_d.cont = (sh[7:4] == QRS_CONT_NIBBLE);
               s_d.st = QRS_LK_DUMMY;
            end
         end
         QRS_LK_DUMMY: begin
            s_d.cnt = c.cnt + 5'd1;
            if (c.cnt + 5'd1 == rem) begin
               s_d.st = QRS_LK_RDATA;
               s_d.nib = 1'b0;
            end
         end
         QRS_LK_RDATA: begin
            s_d.nib = !c.nib;
            if (c.nib) begin
               if (!cfg.fwm && cfg.wrap_en) begin
                  s_d.addr = (c.addr & ~wmask) | ((c.addr + 24'h00_0001) & wmask);
               end else begin
                  s_d.addr = c.addr + 24'h00_0001;
               end
            end
         end
         QRS_LK_WDATA: begin
            s_d.sh = sh;
            s_d.cnt = cnt;
            s_d.done = 1'b0;
            if (cnt == 5'd8) begin
               s_d.cnt = '0;
               pb_we = 1'b1;
               s_d.addr[7:0] = c.addr[7:0] + 8'h01;
               s_d.done = 1'b1;
            end
         end
         QRS_LK_EDONE: begin
            s_d.done = 1'b0;
            s_d.st = QRS_LK_IGNORE;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: QRS_LK_IGNORE, op: QRS_OP_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_addr_q = s_q.addr;

   // Drive read data on the falling edge, release as soon as cs_n rises
   always_ff @(negedge sck or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         io_out_q <= '0;
         io_oe_q <= '0;
      end else if (cs_n) begin
         io_out_q <= '0;
         io_oe_q <= '0;
      end else begin
         io_out_q <= s_q.nib ? rd_data[3:0] : rd_data[7:4];
         io_oe_q <= {4{fl_q && s_q.st == QRS_LK_RDATA}};
      end
   end

   qrs_pagebuf #(.DEPTH(QRS_PAGE_BYTES), .WIDTH(8)) u_pagebuf (
      .wclk(sck),
      .rst_n(rst_n),
      .clr(pb_clr),
      .we(pb_we),
      .waddr(c.addr[7:0]),
      .wdata(sh),
      .raddr(y_q.idx),
      .rdata(pb_rdata),
      .rmark(pb_rmark)
   );

   // ------------------------------------------------------------
   // Core side: commit, array walk and self-timed cycle
   // ------------------------------------------------------------
   logic cs_rise;

   always_comb begin
      y_d = y_q;
      y_d.csd = cs_s;
      y_d.arr.wr_en = 1'b0;
      y_d.arr.erase = 1'b0;
      cs_rise = !cs_s && y_q.csd;
      case (y_q.st)
         QRS_SY_IDLE: begin
            if (cs_rise && s_q.write_enable_cmd) begin
               y_d.wl = 1'b1;
            end
            if (cs_rise && s_q.done && s_q.op == QRS_OP_PROG) begin
               y_d.busy = 1'b1;
               y_d.wl = 1'b0;
               y_d.page = s_q.addr[23:8];
               y_d.idx = '0;
               y_d.tmr = PROG_CYC;
               y_d.st = QRS_SY_COPY;
            end else if (cs_rise && s_q.done && s_q.op == QRS_OP_ERASE) begin
               y_d.busy = 1'b1;
               y_d.wl = 1'b0;
               y_d.arr.erase = 1'b1;
               y_d.arr.big = s_q.big;
               y_d.arr.addr = s_q.addr & ~(s_q.big ? QRS_MID_BLK_MASK :
                                           QRS_SMALL_BLK_MASK);
               y_d.tmr = s_q.big ? MID_CYC : SMALL_CYC;
               y_d.st = QRS_SY_WAIT;
            end
         end
         QRS_SY_COPY: begin
            y_d.arr.wr_en = pb_rmark;
            y_d.arr.addr = {y_q.page, y_q.idx};
            y_d.arr.data = pb_rdata;
            y_d.idx = y_q.idx + 8'h01;
            if (y_q.idx == 8'hFF) begin
               y_d.st = QRS_SY_WAIT;
            end
         end
         QRS_SY_WAIT: begin
            y_d.tmr = y_q.tmr - 32'h0000_0001;
            if (y_q.tmr == 32'h0000_0001) begin
               y_d.busy = 1'b0;
               y_d.st = QRS_SY_IDLE;
            end
         end
         default: begin
            y_d.st = QRS_SY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         y_q <= '{st: QRS_SY_IDLE, default: '0};
      end else begin
         y_q <= y_d;
      end
   end

   assign busy_q = y_q.busy;
   assign write_latch_flag_q = y_q.wl;
   assign arr_q = y_q.arr;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_qe_gate;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (s_q.st == QRS_LK_CMD && fl_q && s_d.op == QRS_OP_READ) |-> cfg.qe;
   endproperty
   a_qe_gate: assert property (p_qe_gate) else $error("quad read taken without quad enable");

   property p_wl_gate;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (fl_q && s_q.st == QRS_LK_CMD && s_d.st == QRS_LK_ADDR && s_d.op != QRS_OP_READ)
         |-> (cfg.wl && !cfg.busy);
   endproperty
   a_wl_gate: assert property (p_wl_gate) else $error("program or erase taken without latch");

   property p_dummy_eight;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (s_q.st == QRS_LK_RDATA && $past(s_q.st) == QRS_LK_DUMMY && cfg.fwm &&
          $past(cfg.dsel, 2) == 2'b11 && $past(cfg.fwm, 8)) |-> $past(s_q.st, 7) == QRS_LK_MODE;
   endproperty
   a_dummy_eight: assert property (p_dummy_eight) else $error("eight dummy clocks not kept");

   property p_cont_skip;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (!fl_q && s_q.cont) |=> (s_q.op == QRS_OP_READ && s_q.st == QRS_LK_ADDR);
   endproperty
   a_cont_skip: assert property (p_cont_skip) else $error("continuous read did not skip opcode");

   property p_wrap_hold;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (s_q.st == QRS_LK_RDATA && $past(s_q.st) == QRS_LK_RDATA && !cfg.fwm && cfg.wrap_en &&
          $stable(cfg.wrap_len)) |-> ((s_q.addr & ~wmask) == ($past(s_q.addr) & ~wmask));
   endproperty
   a_wrap_hold: assert property (p_wrap_hold) else $error("wrapped read left its section");

   property p_page_hold;
      @(posedge sck) disable iff (!rst_n || cs_n)
         (s_q.st == QRS_LK_WDATA && $rose(s_q.done)) |->
         s_q.addr == {$past(s_q.addr[23:8]), 8'($past(s_q.addr[7:0]) + 8'h01)};
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("program address left its page");

   property p_busy_clears_wl;
      @(posedge clk_sys) disable iff (!rst_n)
         $rose(busy_q) |-> !write_latch_flag_q;
   endproperty
   a_busy_clears_wl: assert property (p_busy_clears_wl) else $error("latch kept while busy");

   property p_partial_drop;
      @(posedge clk_sys) disable iff (!rst_n)
         (y_q.st == QRS_SY_IDLE && cs_rise && !s_q.done) |=> !busy_q;
   endproperty
   a_partial_drop: assert property (p_partial_drop) else $error("incomplete command executed");

   property p_busy_end;
      @(posedge clk_sys) disable iff (!rst_n)
         (y_q.st == QRS_SY_WAIT && y_q.tmr == 32'h0000_0001) |=> (!busy_q ##1 !busy_q);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy not released at cycle end");

   property p_erase_start;
      @(posedge clk_sys) disable iff (!rst_n)
         (y_q.st == QRS_SY_IDLE && cs_rise && s_q.done && s_q.op == QRS_OP_ERASE) |=>
         (arr_q.erase && busy_q && arr_q.addr[11:0] == 12'h000);
   endproperty
   a_erase_start: assert property (p_erase_start) else $error("erase not started");
endmodule : qrs_seq

//--- verif/qrs_host_model.sv
// Purpose: Host flash controller model on the serial link
// Assumes: Mode 0 timing, 6 ns link clock running only inside frames
// Notes:   Released lines show a pattern that flips every put or idle clock
`timescale 1ns/1ps
module qrs_host_model (
   output logic sck,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out_q,
   input wire logic [3:0] io_oe_q
);
   logic [3:0] drv;
   logic [3:0] hen = 4'h0;
   logic [3:0] alt = 4'h5;
   assign io_in = (io_oe_q & io_out_q) | (~io_oe_q & ((hen & drv) | (~hen & alt)));
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
   end
   task automatic clk1;
      #3 sck = 1'b1;
      #3 sck = 1'b0;
      alt = ~alt;
   endtask : clk1
   task automatic open_frame;
      cs_n = 1'b0;
      #3;
   endtask : open_frame
   task automatic put(input logic [31:0] v, input int n, input bit q);
      for (int i = n - 1; i >= 0; i--) begin
         hen = q ? 4'hF : 4'h1;
         drv = q ? v[4*i +: 4] : {3'b000, v[i]};
         clk1();
      end
   endtask : put
   task automatic idle(input int n);
      hen = 4'h0;
      repeat (n) clk1();
   endtask : idle
   task automatic get(output logic [7:0] b);
      #3 sck = 1'b1;
      b[7:4] = io_in;
      #3 sck = 1'b0;
      #3 sck = 1'b1;
      b[3:0] = io_in;
      #3 sck = 1'b0;
   endtask : get
   task automatic close_frame;
      hen = 4'h0;
      #3 cs_n = 1'b1;
      #240;
   endtask : close_frame
endmodule : qrs_host_model

//--- verif/qrs_seq_bench.sv
// Purpose: Self-checking bench for the quad read, program and erase sequencer
// Assumes: Shortened self-timed parameters; array byte is a fixed function of address
// Notes:   Array pulses are matched against a queue of expected entries
`timescale 1ns/1ps
module qrs_seq_bench;
   import qrs_pkg::*;
   localparam int PCYC = 256 + 1000 / QRS_CLK_NS;
   localparam int NW = 32'h0100_0000;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sck, cs_n, busy_q, write_latch_flag_q, quad_en = 1'b0, fw_mode = 1'b0, wrap_en = 1'b0;
   logic [3:0] io_in, io_out_q, io_oe_q;
   logic [23:0] rd_addr_q;
   logic [1:0] wrap_len = 2'b00, dummy_sel = 2'b00;
   qrs_arr_s arr_q;
   qrs_arr_s exp_q[$];
   int err_count = 0, checks = 0;
   logic [31:0] seed = 32'h1b99_0524;
   always #20 clk_sys = ~clk_sys;
   qrs_seq #(.PROG_TIME_US(1), .SMALL_ERASE_TIME_US(2), .MID_ERASE_TIME_US(3)) qrs_seq_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
      .io_out_q(io_out_q), .io_oe_q(io_oe_q), .rd_addr_q(rd_addr_q),
      .rd_data(rd_addr_q[7:0] ^ rd_addr_q[15:8]), .quad_enable_bit(quad_en),
      .four_wire_command_mode(fw_mode), .wrap_en(wrap_en), .wrap_len(wrap_len),
      .dummy_sel(dummy_sel), .busy_q(busy_q), .write_latch_flag_q(write_latch_flag_q),
      .arr_q(arr_q));
   qrs_host_model qrs_host_model_inst (.sck(sck), .cs_n(cs_n), .io_in(io_in),
      .io_out_q(io_out_q), .io_oe_q(io_oe_q));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [39:0] mask(input qrs_arr_s a);
      return {a.wr_en, a.erase, a.erase & a.big, a.addr, a.wr_en ? a.data : 8'h00};
   endfunction : mask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   always @(negedge clk_sys) begin
      if (arr_q.wr_en === 1'b1 || arr_q.erase === 1'b1) begin
         if (exp_q.size() == 0) chk(1, 0);
         else chk(mask(arr_q), mask(exp_q.pop_front()));
      end
   end
   task automatic write_enable_cmd;
      qrs_host_model_inst.open_frame();
      qrs_host_model_inst.put(QRS_OPC_WRITE_ENABLE_CMD, 8, 0);
      qrs_host_model_inst.close_frame();
      chk(write_latch_flag_q, 1);
   endtask : write_enable_cmd
   task automatic run(input logic [7:0] opc, input logic [23:0] a, input int nd,
                      input int extra, input bit ok, input int cyc);
      logic [7:0] d1, d2;
      bit q;
      int n;
      q = (opc == QRS_OPC_QPROG);
      seed = lfsr(seed);
      {d1, d2} = seed[15:0];
      if (ok && nd == 0) exp_q.push_back('{1'b0, 1'b1, opc == QRS_OPC_ERASE_MID,
         a & ~(opc == QRS_OPC_ERASE_MID ? QRS_MID_BLK_MASK : QRS_SMALL_BLK_MASK), 8'h00});
      if (ok && nd != 0) begin
         exp_q.push_back('{1'b1, 1'b0, 1'b0, {a[23:8], 8'h00}, d2});
         exp_q.push_back('{1'b1, 1'b0, 1'b0, a, d1});
      end
      qrs_host_model_inst.open_frame();
      qrs_host_model_inst.put(opc, 8, 0);
      qrs_host_model_inst.put(a, q ? 6 : 24, q);
      qrs_host_model_inst.put({d1, d2}, nd * (q ? 2 : 8), q);
      qrs_host_model_inst.put(0, extra, 0);
      qrs_host_model_inst.close_frame();
      chk(busy_q, ok);
      if (ok) chk(write_latch_flag_q, 0);
      n = 0;
      while (busy_q === 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      chk(n + 8 >= cyc && n <= cyc + 2, 1);
      chk(exp_q.size(), 0);
   endtask : run
   task automatic rd(input bit skip, input logic [23:0] a, input logic [7:0] m, input int dum,
                     input int n, input int len);
      logic [23:0] e;
      logic [7:0] b;
      qrs_host_model_inst.open_frame();
      if (!skip) qrs_host_model_inst.put(QRS_OPC_QREAD, fw_mode ? 2 : 8, fw_mode);
      qrs_host_model_inst.put(a, 6, 1);
      qrs_host_model_inst.put(m, 2, 1);
      qrs_host_model_inst.idle(dum);
      for (int i = 0; i < n; i++) begin
         qrs_host_model_inst.get(b);
         e = 24'((a & ~(len - 1)) | ((a + i) & (len - 1)));
         if (quad_en) chk(b, e[7:0] ^ e[15:8]);
         else chk(io_oe_q, 4'h0);
      end
      qrs_host_model_inst.close_frame();
   endtask : rd
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      write_enable_cmd();
      run(QRS_OPC_PROG, 24'h00_12FF, 2, 3, 0, 0);
      run(QRS_OPC_ERASE_SMALL, 24'h00_5ABC, 0, 1, 0, 0);
      run(QRS_OPC_ERASE_SMALL, 24'h00_5ABC, 0, 0, 1, 1000 / QRS_CLK_NS * 2);
      run(QRS_OPC_ERASE_MID, 24'h01_9ABC, 0, 0, 0, 0);
      write_enable_cmd();
      run(QRS_OPC_QPROG, 24'h00_34FF, 2, 0, 0, 0);
      rd(0, 24'h00_0106, 8'hA5, 4, 1, NW);
      @(negedge clk_sys) quad_en = 1'b1;
      run(QRS_OPC_QPROG, 24'h00_34FF, 2, 0, 1, PCYC);
      write_enable_cmd();
      run(QRS_OPC_ERASE_MID, 24'h01_9ABC, 0, 0, 1, 1000 / QRS_CLK_NS * 3);
      write_enable_cmd();
      run(QRS_OPC_PROG, 24'h00_12FF, 2, 0, 1, PCYC);
      rd(0, 24'h00_0106, 8'hA5, 4, 2, NW);
      rd(1, 24'h00_0200, 8'h50, 4, 2, NW);
      rd(0, 24'h00_0300, 8'h00, 4, 1, NW);
      @(negedge clk_sys) wrap_en = 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys) wrap_len = 2'(k);
         rd(0, 24'h00_0400 + 24'((8 << k) - 1), 8'h00, 4, 2, 8 << k);
      end
      @(negedge clk_sys) fw_mode = 1'b1;
      qrs_host_model_inst.open_frame();
      qrs_host_model_inst.idle(2);
      qrs_host_model_inst.close_frame();
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys) dummy_sel = 2'(k);
         rd(0, 24'h00_053F, k == 3 ? 8'hA0 : 8'h00, k < 2 ? 2 : 2 * k, 2, NW);
      end
      rd(1, 24'h00_0600, 8'h00, 6, 2, NW);
      report_and_stop();
   end
   initial begin
      #500_000;
      err_count++;
      report_and_stop();
   end
endmodule : qrs_seq_bench
